// ### src/pbc_prbs7_checker.sv
// prbs7 error checker with timed and continuous runs, lock and rate tallies, avalon-mm registers
// ==========================================
`timescale 1ns/100ps

module pbc_prbs7_checker (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [pbc_pkg::ADDR_W-1:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWriteData,
	output logic [31:0] avsReadData,
	output logic avsWaitrequest,
	input wire logic eqSerialData,
	input wire logic eqSerialStrobe,
	input wire logic cdrLock,
	input wire logic [2:0] cdrRate
);

	// ==========================================
	// pin synchronisers
	pbc_pkg::pbc_link_t linkS1_q;
	pbc_pkg::pbc_link_t linkS2_q;
	pbc_pkg::pbc_link_t linkS3_q;

	// checker input is the equalized pin only
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			linkS1_q <= '0;
			linkS2_q <= '0;
			linkS3_q <= '0;
		end else begin
			linkS1_q <= pbc_link_t_pack(eqSerialData, eqSerialStrobe, cdrLock, cdrRate);
			linkS2_q <= linkS1_q;
			linkS3_q <= linkS2_q;
		end
	end

	function automatic pbc_pkg::pbc_link_t pbc_link_t_pack(
		input logic d,
		input logic s,
		input logic l,
		input logic [2:0] r
	);
		pbc_pkg::pbc_link_t v;
		v.data = d;
		v.strobe = s;
		v.lock = l;
		v.rate = r;
		return v;
	endfunction

	// qualified levels: a change counts once stages two and three agree
	logic strobeLvl_q;
	logic lockLvl_q;
	logic [2:0] rateLvl_q;
	logic bitEvent_q;
	logic bitData_q;
	logic lockChange;
	logic rateChange;

	assign lockChange = (linkS2_q.lock == linkS3_q.lock) && (linkS3_q.lock != lockLvl_q);
	assign rateChange = (linkS2_q.rate == linkS3_q.rate) && (linkS3_q.rate != rateLvl_q);

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			strobeLvl_q <= 1'b0;
			lockLvl_q <= 1'b0;
			rateLvl_q <= 3'h0;
			bitEvent_q <= 1'b0;
			bitData_q <= 1'b0;
		end else begin
			bitEvent_q <= 1'b0;
			if (linkS2_q.strobe == linkS3_q.strobe) begin
				strobeLvl_q <= linkS3_q.strobe;
				if (linkS3_q.strobe && !strobeLvl_q) begin
					bitEvent_q <= 1'b1;
					bitData_q <= linkS3_q.data;
				end
			end
			if (lockChange) begin
				lockLvl_q <= linkS3_q.lock;
			end
			if (rateChange) begin
				rateLvl_q <= linkS3_q.rate;
			end
		end
	end

	// ==========================================
	// lock and rate tallies
	logic [7:0] lockChangeTally_q;
	logic [7:0] rateChangeTally_q;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			lockChangeTally_q <= 8'h00;
			rateChangeTally_q <= 8'h00;
		end else begin
			if (lockChange) begin
				lockChangeTally_q <= lockChangeTally_q + 8'h01;
			end
			if (rateChange) begin
				rateChangeTally_q <= rateChangeTally_q + 8'h01;
			end
		end
	end

	// ==========================================
	// registers
	pbc_pkg::pbc_timing_t timing_q;
	pbc_pkg::pbc_control_t control_q;
	pbc_pkg::pbc_state_t state_q;
	logic lastAbort_q;
	logic [15:0] errorTotal_q;
	logic waitReq_q;
	logic [31:0] readData_q;
	logic [7:0] regIdx;
	logic busReq;
	logic busAccept;

	assign regIdx = avsAddress[pbc_pkg::ADDR_W-1:2];
	assign busReq = avsRead || avsWrite;
	assign busAccept = busReq && !waitReq_q;

	// one wait cycle, then the access completes
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			waitReq_q <= 1'b1;
		end else begin
			waitReq_q <= !(busReq && waitReq_q);
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			timing_q.windowPrescaleSel <= pbc_pkg::RST_PRESCALE_SEL;
			timing_q.windowInterval <= pbc_pkg::RST_INTERVAL;
			control_q <= '0;
		end else if (busAccept && avsWrite) begin
			if (regIdx == pbc_pkg::IDX_PATTERN_CHECK_TIMING) begin
				timing_q <= avsWriteData[15:0];
			end else if (regIdx == pbc_pkg::IDX_PATTERN_CHECK_CONTROL) begin
				control_q.runRequest <= avsWriteData[pbc_pkg::CTRL_START_BIT];
				control_q.timedNotContinuous <= avsWriteData[pbc_pkg::CTRL_TIMED_BIT];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			readData_q <= 32'h0000_0000;
		end else if (busReq && waitReq_q) begin
			readData_q <= 32'h0000_0000;
			if (!avsRead) begin
				readData_q <= 32'h0000_0000;
			end else if (regIdx == pbc_pkg::IDX_PATTERN_CHECK_TIMING) begin
				readData_q[15:0] <= timing_q;
			end else if (regIdx == pbc_pkg::IDX_PATTERN_CHECK_CONTROL) begin
				readData_q[pbc_pkg::CTRL_START_BIT] <= control_q.runRequest;
				readData_q[pbc_pkg::CTRL_TIMED_BIT] <= control_q.timedNotContinuous;
			end else if (regIdx == pbc_pkg::IDX_LOCK_EVENT_COUNTS) begin
				readData_q[15:0] <= {rateChangeTally_q, lockChangeTally_q};
			end else if (regIdx == pbc_pkg::IDX_LOCK_STATE_NOW) begin
				readData_q[0] <= lockLvl_q;
			end else if (regIdx == pbc_pkg::IDX_PATTERN_ERROR_TOTAL) begin
				readData_q[15:0] <= errorTotal_q;
			end else if (regIdx == pbc_pkg::IDX_PATTERN_CHECK_STATE) begin
				readData_q[1:0] <= state_q;
				readData_q[pbc_pkg::STAT_LAST_ABORT_BIT] <= lastAbort_q;
			end
		end
	end

	assign avsReadData = readData_q;
	assign avsWaitrequest = waitReq_q;

	// ==========================================
	// 40 MHz tick and window timer
	logic [2:0] tickDiv_q;
	logic tick_q;
	logic [5:0] prescaleCnt_q;
	logic [21:0] windowCnt_q;
	logic windowDone;
	logic [5:0] prescaleDivisor;
	logic [21:0] windowLast;

	assign prescaleDivisor = pbc_pkg::PRESCALE_BASE << timing_q.windowPrescaleSel;
	// last window count is interval*256, so the window spans interval*256+1 prescaled ticks
	assign windowLast = {timing_q.windowInterval, pbc_pkg::INTERVAL_LOW_BITS};
	assign windowDone = tick_q && (prescaleCnt_q == prescaleDivisor - 6'h01) && (windowCnt_q == windowLast);

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			tickDiv_q <= 3'h0;
			tick_q <= 1'b0;
		end else begin
			tick_q <= (tickDiv_q == 3'(pbc_pkg::TICK_DIV - 1));
			if (tickDiv_q == 3'(pbc_pkg::TICK_DIV - 1)) begin
				tickDiv_q <= 3'h0;
			end else begin
				tickDiv_q <= tickDiv_q + 3'h1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			prescaleCnt_q <= 6'h00;
			windowCnt_q <= 22'h000000;
		end else if (state_q != pbc_pkg::PBC_RUNNING) begin
			prescaleCnt_q <= 6'h00;
			windowCnt_q <= 22'h000000;
		end else if (tick_q) begin
			if (prescaleCnt_q == prescaleDivisor - 6'h01) begin
				prescaleCnt_q <= 6'h00;
				windowCnt_q <= windowCnt_q + 22'h000001;
			end else begin
				prescaleCnt_q <= prescaleCnt_q + 6'h01;
			end
		end
	end

	// ==========================================
	// run handshake
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= pbc_pkg::PBC_READY;
			lastAbort_q <= 1'b0;
		end else begin
			case (state_q)
				pbc_pkg::PBC_READY: begin
					if (control_q.runRequest) begin
						if (lockLvl_q) begin
							state_q <= pbc_pkg::PBC_RUNNING;
						end else begin
							state_q <= pbc_pkg::PBC_ABORTED;
							lastAbort_q <= 1'b1;
						end
					end
				end
				pbc_pkg::PBC_RUNNING: begin
					if (!lockLvl_q) begin
						state_q <= pbc_pkg::PBC_ABORTED;
						lastAbort_q <= 1'b1;
					end else if (control_q.timedNotContinuous && windowDone) begin
						state_q <= pbc_pkg::PBC_DONE;
						lastAbort_q <= 1'b0;
					end else if (!control_q.timedNotContinuous && !control_q.runRequest) begin
						state_q <= pbc_pkg::PBC_READY;
						lastAbort_q <= 1'b0;
					end
				end
				default: begin
					if (!control_q.runRequest) begin
						state_q <= pbc_pkg::PBC_READY;
					end
				end
			endcase
		end
	end

	// ==========================================
	// prbs7 compare, x^7 + x^6 + 1, self seeding
	logic [6:0] history_q;
	logic [2:0] seedCnt_q;
	logic expectedBit;

	assign expectedBit = history_q[6] ^ history_q[5];

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			history_q <= 7'h00;
			seedCnt_q <= 3'h0;
		end else if (state_q != pbc_pkg::PBC_RUNNING) begin
			history_q <= 7'h00;
			seedCnt_q <= 3'h0;
		end else if (bitEvent_q) begin
			history_q <= {history_q[5:0], bitData_q};
			if (seedCnt_q != 3'h7) begin
				seedCnt_q <= seedCnt_q + 3'h1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			errorTotal_q <= 16'h0000;
		end else if (state_q == pbc_pkg::PBC_READY && control_q.runRequest) begin
			errorTotal_q <= 16'h0000;
		end else if (state_q == pbc_pkg::PBC_RUNNING && bitEvent_q && seedCnt_q == 3'h7) begin
			if (bitData_q != expectedBit && errorTotal_q != 16'hFFFF) begin
				errorTotal_q <= errorTotal_q + 16'h0001;
			end
		end
	end

endmodule

// ### src/pbc_pkg.sv
// shared constants and types for the prbs7 error checker
package pbc_pkg;

	// ==========================================
	// register indices and byte address width
	localparam logic [7:0] IDX_PATTERN_CHECK_TIMING = 8'h50;
	localparam logic [7:0] IDX_PATTERN_CHECK_CONTROL = 8'h51;
	localparam logic [7:0] IDX_LOCK_EVENT_COUNTS = 8'h85;
	localparam logic [7:0] IDX_LOCK_STATE_NOW = 8'h86;
	localparam logic [7:0] IDX_PATTERN_ERROR_TOTAL = 8'h89;
	localparam logic [7:0] IDX_PATTERN_CHECK_STATE = 8'h8A;
	localparam int ADDR_W = 10;

	// ==========================================
	// field positions
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_TIMED_BIT = 1;
	localparam int STAT_LAST_ABORT_BIT = 2;
	localparam int CNT_RATE_LSB = 8;

	// ==========================================
	// reset values
	localparam logic [1:0] RST_PRESCALE_SEL = 2'h0;
	localparam logic [13:0] RST_INTERVAL = 14'h0003;

	// ==========================================
	// timing
	localparam longint SYS_CLK_HZ = 200000000;
	localparam longint TICK_HZ = 40000000;
	localparam int TICK_DIV = int'(SYS_CLK_HZ / TICK_HZ);
	localparam logic [5:0] PRESCALE_BASE = 6'h04;
	localparam logic [7:0] INTERVAL_LOW_BITS = 8'h00;

	// ==========================================
	// types
	typedef enum logic [1:0] {
		PBC_READY = 2'b00,
		PBC_RUNNING = 2'b01,
		PBC_DONE = 2'b10,
		PBC_ABORTED = 2'b11
	} pbc_state_t;

	typedef struct packed {
		logic [1:0] windowPrescaleSel;
		logic [13:0] windowInterval;
	} pbc_timing_t;

	typedef struct packed {
		logic timedNotContinuous;
		logic runRequest;
	} pbc_control_t;

	typedef struct packed {
		logic data;
		logic strobe;
		logic lock;
		logic [2:0] rate;
	} pbc_link_t;

endpackage

// ### dv/pbc_link_source.sv
// prbs7 serial source standing in for the recovered link
`timescale 1ns/100ps
module pbc_link_source (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic flipReq,
	output logic serialData,
	output logic serialStrobe
);
	// ==========================================
	// free running strobe, one bit per 8 cycles
	logic [6:0] lfsr_q;
	logic [2:0] phase_q;
	logic flip_q;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			lfsr_q <= 7'h7F;
			phase_q <= 3'h0;
			flip_q <= 1'b0;
			serialData <= 1'b0;
			serialStrobe <= 1'b0;
		end else begin
			phase_q <= phase_q + 3'h1;
			serialStrobe <= phase_q[2];
			if (flipReq) begin
				flip_q <= 1'b1;
			end
			if (phase_q == 3'h1) begin
				lfsr_q <= {lfsr_q[5:0], lfsr_q[6] ^ lfsr_q[5]};
				serialData <= lfsr_q[6] ^ lfsr_q[5] ^ flip_q;
				flip_q <= flipReq;
			end
		end
	end
endmodule

// ### dv/pbc_port_checker.sv
// port assertions for the prbs7 error checker
`timescale 1ns/100ps
module pbc_port_checker (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [pbc_pkg::ADDR_W-1:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsReadData,
	input wire logic avsWaitrequest,
	input wire logic cdrLock
);
	// ==========================================
	// helpers and assertions
	logic [3:0] lockAge_q;
	logic lockPrev_q;
	logic rdDone;
	logic [7:0] idx;
	assign idx = avsAddress[9:2];
	assign rdDone = avsRead && !avsWaitrequest;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			lockPrev_q <= 1'b0;
			lockAge_q <= 4'h0;
		end else begin
			lockPrev_q <= cdrLock;
			lockAge_q <= (cdrLock != lockPrev_q) ? 4'h0 : (lockAge_q == 4'hF ? 4'hF : lockAge_q + 4'h1);
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	a_wait_one_cycle: assert property (!avsWaitrequest |=> avsWaitrequest) else $error("wait low too long");
	a_req_answered: assert property ((avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest) else $error("no answer");
	a_wait_has_cause: assert property ($fell(avsWaitrequest) |-> $past(avsRead || avsWrite)) else $error("stray answer");
	a_unmapped_zero: assert property (rdDone && idx[7:6] == 2'h0 |-> avsReadData == 32'h0) else $error("unmapped data");
	a_upper_half_zero: assert property (rdDone |-> avsReadData[31:16] == 16'h0) else $error("upper half set");
	a_lock_bit_now: assert property (rdDone && idx == pbc_pkg::IDX_LOCK_STATE_NOW && lockAge_q == 4'hF
		|-> avsReadData[15:0] == {15'h0, cdrLock}) else $error("lock bit wrong");
	a_state_field_width: assert property (rdDone && idx == pbc_pkg::IDX_PATTERN_CHECK_STATE
		|-> avsReadData[15:3] == 13'h0) else $error("state high bits set");
	a_read_data_hold: assert property (avsWaitrequest |-> $stable(avsReadData)) else $error("read data moved");
	c_done: cover property (rdDone && idx == pbc_pkg::IDX_PATTERN_CHECK_STATE && avsReadData[1:0] == 2'h2);
	c_abort: cover property (rdDone && idx == pbc_pkg::IDX_PATTERN_CHECK_STATE && avsReadData[1:0] == 2'h3);
	c_lock_read: cover property (rdDone && idx == pbc_pkg::IDX_LOCK_STATE_NOW && lockAge_q == 4'hF);
endmodule
bind pbc_prbs7_checker pbc_port_checker u_chk (.sys_clk(sys_clk), .arst_n(arst_n), .avsAddress(avsAddress),
	.avsRead(avsRead), .avsWrite(avsWrite), .avsReadData(avsReadData), .avsWaitrequest(avsWaitrequest),
	.cdrLock(cdrLock));

// ### dv/pbc_prbs7_checker_bench.sv
// register level tests of the prbs7 error checker
`timescale 1ns/100ps
module pbc_prbs7_checker_bench;
	// ==========================================
	// signals, tasks and test sequence
	localparam logic [7:0] TM = pbc_pkg::IDX_PATTERN_CHECK_TIMING;
	localparam logic [7:0] CT = pbc_pkg::IDX_PATTERN_CHECK_CONTROL;
	localparam logic [7:0] ST = pbc_pkg::IDX_PATTERN_CHECK_STATE;
	localparam logic [7:0] ER = pbc_pkg::IDX_PATTERN_ERROR_TOTAL;
	localparam logic [7:0] LC = pbc_pkg::IDX_LOCK_EVENT_COUNTS;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [pbc_pkg::ADDR_W-1:0] avsAddress = '0;
	logic avsRead = 1'b0;
	logic avsWrite = 1'b0;
	logic [31:0] avsWriteData = 32'h0;
	logic [31:0] avsReadData;
	logic avsWaitrequest;
	logic serData;
	logic serStrobe;
	logic cdrLock = 1'b0;
	logic [2:0] cdrRate = 3'h0;
	logic flipReq = 1'b0;
	logic [15:0] rd = 16'h0;
	logic [15:0] base;
	int miscompares = 0;
	int checked = 0;
	int cycles = 0;
	int t0;
	always #2.5 sys_clk = ~sys_clk;
	pbc_link_source u_src (.sys_clk(sys_clk), .arst_n(arst_n), .flipReq(flipReq), .serialData(serData),
		.serialStrobe(serStrobe));
	pbc_prbs7_checker u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .avsAddress(avsAddress), .avsRead(avsRead),
		.avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsReadData(avsReadData),
		.avsWaitrequest(avsWaitrequest), .eqSerialData(serData), .eqSerialStrobe(serStrobe),
		.cdrLock(cdrLock), .cdrRate(cdrRate));
	task automatic summarize();
		$display("compares=%0d mismatches=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic access(input logic wr, input logic [7:0] idx, input logic [15:0] wd);
		avsAddress <= {idx, 2'b00};
		avsWrite <= wr;
		avsRead <= ~wr;
		avsWriteData <= {16'h0, wd};
		@(posedge sys_clk);
		while (avsWaitrequest !== 1'b0) @(posedge sys_clk);
		rd = avsReadData[15:0];
		avsWrite <= 1'b0;
		avsRead <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rdc(input logic [7:0] idx, input logic [15:0] exp, input logic [15:0] mask);
		access(1'b0, idx, 16'h0);
		cmp(rd & mask, exp);
	endtask
	task automatic waitState(input logic [1:0] st);
		int i;
		i = 0;
		do begin
			access(1'b0, ST, 16'h0);
			i++;
		end while (i < 200 && rd[1:0] !== st);
	endtask
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			summarize();
		end
	end
	initial begin
		repeat (3) @(posedge sys_clk);
		arst_n <= 1'b1;
		@(posedge sys_clk);
		rdc(TM, 16'h0003, 16'hFFFF);
		rdc(ST, 16'h0000, 16'h0007);
		rdc(8'h3C, 16'h0000, 16'hFFFF);
		access(1'b1, ER, 16'h1234);
		rdc(ER, 16'h0000, 16'hFFFF);
		access(1'b1, CT, 16'h0003);
		waitState(2'h3);
		cmp(rd & 16'h0007, 16'h0007);
		access(1'b1, CT, 16'h0002);
		rdc(ST, 16'h0000, 16'h0003);
		cdrLock <= 1'b1;
		cdrRate <= 3'h1;
		repeat (20) @(posedge sys_clk);
		rdc(pbc_pkg::IDX_LOCK_STATE_NOW, 16'h0001, 16'hFFFF);
		rdc(LC, 16'h0001, 16'h00FF);
		base = rd;
		cdrRate <= 3'h2;
		repeat (20) @(posedge sys_clk);
		rdc(LC, (base & 16'hFF00) + 16'h0100, 16'hFF00);
		for (int s = 0; s < 4; s++) begin
			access(1'b1, TM, {s[1:0], 14'h0});
			access(1'b1, CT, 16'h0003);
			t0 = cycles;
			rdc(ST, 16'h0001, 16'h0003);
			waitState(2'h2);
			cmp(rd & 16'h0007, 16'h0002);
			cmp(16'(cycles - t0 >= (20 << s) - 2 && cycles - t0 <= (20 << s) + 20), 16'h1);
			rdc(ER, 16'h0000, 16'hFFFF);
			access(1'b1, CT, 16'h0002);
			rdc(ST, 16'h0000, 16'h0003);
		end
		access(1'b1, CT, 16'h0001);
		repeat (80) @(posedge sys_clk);
		flipReq <= 1'b1;
		@(posedge sys_clk);
		flipReq <= 1'b0;
		repeat (80) @(posedge sys_clk);
		flipReq <= 1'b1;
		@(posedge sys_clk);
		flipReq <= 1'b0;
		repeat (120) @(posedge sys_clk);
		rdc(ER, 16'h0006, 16'hFFFF);
		rdc(ST, 16'h0001, 16'h0003);
		access(1'b1, CT, 16'h0000);
		rdc(ST, 16'h0000, 16'h0007);
		access(1'b1, CT, 16'h0001);
		rdc(ER, 16'h0000, 16'hFFFF);
		cdrLock <= 1'b0;
		waitState(2'h3);
		cmp(rd & 16'h0007, 16'h0007);
		access(1'b1, CT, 16'h0000);
		rdc(ST, 16'h0000, 16'h0003);
		rdc(LC, (base & 16'h00FF) + 16'h0001, 16'h00FF);
		summarize();
	end
endmodule
